// file: rtl/dsw_exit.sv
// The implementer's own choices: the plain strobed port and the placing of the registers.
`timescale 1ns/1ps
`include "dsw_defines.svh"

// Notes on behaviour
// (RL1) A supply power-on reset wakes the device; any single source suffices.
// (RL2) Watchdog time-out during deep sleep wakes the device.
// (RL3) Calendar alarm wakes only while the calendar enable bit is 1.
// (RL4) Master clear pin low wakes the device.
// (RL5) Interrupt zero wakes only if enabled before entry.
// (RL6) Interrupt polarity picks the pin level that counts as assertion.
// (RL7) Interrupt zero needs a pin change during sleep to wake.
// (RL8) All pending interrupt requests are cleared on entry.
// (RL9) Exit is a full reset; calendar, context and watchdog survive.
// (RL10) Wake events during the exit reset sequence are ignored, not recorded.
// (RL11) Hardware clears the sleep entry enable bit on wake.
// (RL12) After the exit reset, execution restarts at the reset vector.
// (RL13) Exit flag, bit 10 of reset control, set on exit; software clears.
// (RL14) Wake source register records the cause; software reads it.
// (RL15) Brown-out during sleep sets bit 1 of sleep control.
// (RL16) Software reads saved context back from the two context registers.
// (RL17) Software clears the I/O hold bit last.
// (RL18) Pins stay frozen until hold clears, then follow direction and latch.
// (RL19) Master clear wake keeps context, wake source and hold set; control returns to its reset value.
// (RL20) Brown-out or power-on while brown-out is enabled releases pins and loses context.
// (RL21) One separate wake source flag per source.
module dsw_exit (
  // Clock and reset
  input  wire logic        clock,
  input  wire logic        srst,
  // Register port
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_write,
  input  wire logic        reg_read,
  output logic      [15:0] reg_rdata,
  // Sleep request from the core
  input  wire logic        sleep_request,
  // Wake sources
  input  wire logic        supply_por,
  input  wire logic        watchdog_timeout,
  input  wire logic        calendar_alarm,
  input  wire logic        master_clear_n,
  input  wire logic        ext_int_zero,
  input  wire logic        brownout,
  // Core control
  output logic             clear_pending_irq,
  output logic             core_reset,
  output logic             load_reset_vector,
  // I/O port state
  input  wire logic [15:0] io_direction,
  input  wire logic [15:0] io_latch,
  output logic      [15:0] pin_out,
  output logic      [15:0] pin_oe_n
);

  dsw_pkg::dsw_state_t state;
  dsw_pkg::dsw_state_t next_state;
  dsw_pkg::dsw_word_t  ctrl;
  dsw_pkg::dsw_word_t  ctx_a;
  dsw_pkg::dsw_word_t  ctx_b;
  dsw_pkg::dsw_word_t  wake_src;
  dsw_pkg::dsw_word_t  frozen_out;
  dsw_pkg::dsw_word_t  frozen_dir;
  logic                hold;
  logic                bor_flag;
  logic                exit_flag;
  logic [7:0]          por_count;
  logic [5:0]          wake_hits;
  logic                wake_any;
  logic                arm;
  logic                lossy_wake;
  logic                int_armed;

  // -------------------------------------------------------------------------
  // Wake qualification
  // -------------------------------------------------------------------------
  assign arm = (state == dsw_pkg::DSW_RUN) && sleep_request && ctrl[`DSW_CTRL_ENTRY_BIT];

  dsw_wake_detect u_detect (
    .clock            (clock),
    .srst             (srst),
    .asleep           (state == dsw_pkg::DSW_SLEEP),
    .arm              (arm),
    .cal_enable       (ctrl[`DSW_CTRL_CALEN_BIT]),
    .int_enable       (int_armed),
    .int_polarity     (ctrl[`DSW_CTRL_INTPOL_BIT]),
    .supply_por       (supply_por),
    .watchdog_timeout (watchdog_timeout),
    .calendar_alarm   (calendar_alarm),
    .master_clear_n   (master_clear_n),
    .ext_int_zero     (ext_int_zero),
    .brownout         (brownout),
    .wake_hits        (wake_hits)
  );

  // Brown-out only counts as a wake when its detector is enabled.
  assign wake_any   = |{wake_hits[4:0], wake_hits[`DSW_WAKE_BOR_BIT] && ctrl[`DSW_CTRL_BOREN_BIT]}; // RL1
  assign lossy_wake = ctrl[`DSW_CTRL_BOREN_BIT] &&
                      (wake_hits[`DSW_WAKE_BOR_BIT] || wake_hits[`DSW_WAKE_POR_BIT]); // RL20

  // The enable is sampled at entry; later writes cannot arm a sleeping device.
  always_ff @(posedge clock) begin
    if (srst) begin
      int_armed <= 1'b0;
    end else if (arm) begin
      int_armed <= ctrl[`DSW_CTRL_INTEN_BIT]; // RL5
    end
  end

  // -------------------------------------------------------------------------
  // Sequencer
  // -------------------------------------------------------------------------
  always_comb begin
    next_state = state;
    case (state)
      dsw_pkg::DSW_RUN: begin
        if (arm) begin
          next_state = dsw_pkg::DSW_SLEEP;
        end
      end
      dsw_pkg::DSW_SLEEP: begin
        if (wake_any) begin
          next_state = dsw_pkg::DSW_POR;
        end
      end
      dsw_pkg::DSW_POR: begin
        if (por_count == 8'h00) begin
          next_state = dsw_pkg::DSW_RUN;
        end
      end
      default: begin
        next_state = dsw_pkg::DSW_RUN;
      end
    endcase
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      state <= dsw_pkg::DSW_RUN;
    end else begin
      state <= next_state;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      por_count <= 8'h00;
    end else if (state == dsw_pkg::DSW_SLEEP && wake_any) begin
      por_count <= 8'((`DSW_POR_CYCLES) - 1);
    end else if (por_count != 8'h00) begin
      por_count <= por_count - 8'h01;
    end
  end

  assign clear_pending_irq = arm; // RL8
  assign core_reset        = (state == dsw_pkg::DSW_POR); // RL9
  assign load_reset_vector = (state == dsw_pkg::DSW_POR) && (por_count == 8'h00); // RL12

  // -------------------------------------------------------------------------
  // Control word
  // -------------------------------------------------------------------------
  // The exit reset returns the control word to its reset value, which drops the entry enable.
  always_ff @(posedge clock) begin
    if (srst) begin
      ctrl <= `DSW_RESET_CTRL;
    end else if (state == dsw_pkg::DSW_SLEEP && wake_any) begin
      ctrl <= `DSW_RESET_CTRL; // RL11
    end else if (state == dsw_pkg::DSW_RUN && reg_write && reg_addr == `DSW_ADDR_CTRL) begin
      ctrl <= reg_wdata;
    end
  end

  // -------------------------------------------------------------------------
  // Retained status
  // -------------------------------------------------------------------------
  // Only the first wake cycle is captured; later events fall in the reset window.
  always_ff @(posedge clock) begin
    if (srst) begin
      wake_src <= `DSW_RESET_WORD;
    end else if (arm) begin
      wake_src <= `DSW_RESET_WORD;
    end else if (state == dsw_pkg::DSW_SLEEP && wake_any) begin
      wake_src <= {10'h000, wake_hits}; // RL10 RL14 RL21
    end else if (reg_write && reg_addr == `DSW_ADDR_WAKESRC) begin
      wake_src <= `DSW_RESET_WORD;
    end
  end

  // A software clear loses to a simultaneous exit, so the event is kept.
  always_ff @(posedge clock) begin
    if (srst) begin
      exit_flag <= 1'b0;
    end else if (state == dsw_pkg::DSW_SLEEP && wake_any) begin
      exit_flag <= 1'b1; // RL13
    end else if (reg_write && reg_addr == `DSW_ADDR_RESETCON && !reg_wdata[`DSW_RESET_CONTROL_REGISTER_EXIT_BIT]) begin
      exit_flag <= 1'b0;
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      bor_flag <= 1'b0;
    end else if (state == dsw_pkg::DSW_SLEEP && wake_hits[`DSW_WAKE_BOR_BIT]) begin
      bor_flag <= 1'b1; // RL15
    end else if (reg_write && reg_addr == `DSW_ADDR_SLEEPCON && !reg_wdata[`DSW_CON_BOR_BIT]) begin
      bor_flag <= 1'b0;
    end
  end

  // Context survives the exit reset, including master clear, unless the wake is lossy.
  always_ff @(posedge clock) begin
    if (srst) begin
      ctx_a <= `DSW_RESET_WORD;
      ctx_b <= `DSW_RESET_WORD;
    end else if (state == dsw_pkg::DSW_SLEEP && wake_any && lossy_wake) begin
      ctx_a <= `DSW_RESET_WORD; // RL20
      ctx_b <= `DSW_RESET_WORD;
    end else if (state == dsw_pkg::DSW_RUN && reg_write) begin
      if (reg_addr == `DSW_ADDR_CTXA) begin
        ctx_a <= reg_wdata; // RL16
      end
      if (reg_addr == `DSW_ADDR_CTXB) begin
        ctx_b <= reg_wdata;
      end
    end
  end

  // -------------------------------------------------------------------------
  // I/O hold
  // -------------------------------------------------------------------------
  // Hold is set at entry and survives a master clear wake; only software or a lossy wake drops it.
  always_ff @(posedge clock) begin
    if (srst) begin
      hold <= 1'b0;
    end else if (arm) begin
      hold <= 1'b1;
    end else if (state == dsw_pkg::DSW_SLEEP && wake_any && lossy_wake) begin
      hold <= 1'b0; // RL20
    end else if (state == dsw_pkg::DSW_RUN && reg_write && reg_addr == `DSW_ADDR_SLEEPCON &&
                 !reg_wdata[`DSW_CON_HOLD_BIT]) begin
      hold <= 1'b0; // RL17 RL19
    end
  end

  always_ff @(posedge clock) begin
    if (srst) begin
      frozen_out <= `DSW_RESET_WORD;
      frozen_dir <= 16'hFFFF;
    end else if (arm) begin
      frozen_out <= io_latch;
      frozen_dir <= io_direction;
    end
  end

  // Direction bit 1 means input; the enable is low while the pin is driven.
  always_ff @(posedge clock) begin
    if (srst) begin
      pin_out  <= `DSW_RESET_WORD;
      pin_oe_n <= 16'hFFFF;
    end else if (hold) begin
      pin_out  <= frozen_out; // RL18
      pin_oe_n <= frozen_dir;
    end else begin
      pin_out  <= io_latch;
      pin_oe_n <= io_direction;
    end
  end

  // -------------------------------------------------------------------------
  // Read port
  // -------------------------------------------------------------------------
  always_ff @(posedge clock) begin
    if (srst) begin
      reg_rdata <= `DSW_RESET_WORD;
    end else if (reg_read) begin
      case (reg_addr)
        `DSW_ADDR_CTRL:     reg_rdata <= ctrl;
        `DSW_ADDR_SLEEPCON: reg_rdata <= {14'h0000, bor_flag, hold};
        `DSW_ADDR_WAKESRC:  reg_rdata <= wake_src;
        `DSW_ADDR_RESETCON: reg_rdata <= {5'h00, exit_flag, 10'h000};
        `DSW_ADDR_CTXA:     reg_rdata <= ctx_a;
        `DSW_ADDR_CTXB:     reg_rdata <= ctx_b;
        `DSW_ADDR_STATUS:   reg_rdata <= {14'h0000, state};
        default:            reg_rdata <= `DSW_RESET_WORD;
      endcase
    end else begin
      reg_rdata <= `DSW_RESET_WORD;
    end
  end

endmodule

// file: inc/dsw_defines.svh
`ifndef DSW_DEFINES_SVH
`define DSW_DEFINES_SVH

// ---------------------------------------------------------------------------
// Register offsets
// ---------------------------------------------------------------------------
`define DSW_ADDR_CTRL      4'h0
`define DSW_ADDR_SLEEPCON  4'h1
`define DSW_ADDR_WAKESRC   4'h2
`define DSW_ADDR_RESETCON  4'h3
`define DSW_ADDR_CTXA      4'h4
`define DSW_ADDR_CTXB      4'h5
`define DSW_ADDR_STATUS    4'h6

// ---------------------------------------------------------------------------
// Field positions
// ---------------------------------------------------------------------------
`define DSW_CTRL_ENTRY_BIT   0
`define DSW_CTRL_CALEN_BIT   1
`define DSW_CTRL_INTEN_BIT   2
`define DSW_CTRL_INTPOL_BIT  3
`define DSW_CTRL_BOREN_BIT   4
`define DSW_CON_HOLD_BIT     0
`define DSW_CON_BOR_BIT      1
`define DSW_RESET_CONTROL_REGISTER_EXIT_BIT    10
`define DSW_WAKE_POR_BIT     0
`define DSW_WAKE_WDT_BIT     1
`define DSW_WAKE_CAL_BIT     2
`define DSW_WAKE_MASTER_CLEAR_PIN_BIT    3
`define DSW_WAKE_INT_BIT     4
`define DSW_WAKE_BOR_BIT     5

// ---------------------------------------------------------------------------
// Reset values and timing
// ---------------------------------------------------------------------------
`define DSW_RESET_CTRL     16'h0000
`define DSW_RESET_WORD     16'h0000
`define DSW_POR_TIME_NS    1000
`define DSW_CLOCK_MHZ      20
`define DSW_POR_CYCLES     ((`DSW_POR_TIME_NS * `DSW_CLOCK_MHZ + 999) / 1000)

`endif

// file: inc/dsw_pkg.sv
package dsw_pkg;

  typedef enum logic [1:0] {
    DSW_RUN   = 2'b00,
    DSW_SLEEP = 2'b01,
    DSW_POR   = 2'b10
  } dsw_state_t;

  typedef logic [15:0] dsw_word_t;

endpackage

// file: rtl/dsw_wake_detect.sv
`timescale 1ns/1ps
`include "dsw_defines.svh"

module dsw_wake_detect (
  // Clock and reset
  input  wire logic       clock,
  input  wire logic       srst,
  // Sleep control
  input  wire logic       asleep,
  input  wire logic       arm,
  input  wire logic       cal_enable,
  input  wire logic       int_enable,
  input  wire logic       int_polarity,
  // Wake inputs
  input  wire logic       supply_por,
  input  wire logic       watchdog_timeout,
  input  wire logic       calendar_alarm,
  input  wire logic       master_clear_n,
  input  wire logic       ext_int_zero,
  input  wire logic       brownout,
  // Qualified wake flags
  output logic      [5:0] wake_hits
);

  logic int_prev;
  logic int_changed;
  logic int_asserted;

  // The previous pin level is captured at entry, so a level already present cannot wake.
  always_ff @(posedge clock) begin
    if (srst) begin
      int_prev <= 1'b0;
    end else if (arm || asleep) begin
      int_prev <= ext_int_zero;
    end
  end

  assign int_changed  = asleep && (ext_int_zero != int_prev); // RL7
  assign int_asserted = (ext_int_zero == int_polarity); // RL6

  always_comb begin
    wake_hits = 6'h00;
    wake_hits[`DSW_WAKE_POR_BIT]  = asleep && supply_por; // RL1
    wake_hits[`DSW_WAKE_WDT_BIT]  = asleep && watchdog_timeout; // RL2
    wake_hits[`DSW_WAKE_CAL_BIT]  = asleep && calendar_alarm && cal_enable; // RL3
    wake_hits[`DSW_WAKE_MASTER_CLEAR_PIN_BIT] = asleep && !master_clear_n; // RL4
    wake_hits[`DSW_WAKE_INT_BIT]  = int_changed && int_asserted && int_enable; // RL5
    wake_hits[`DSW_WAKE_BOR_BIT]  = asleep && brownout;
  end

endmodule

// file: test/dsw_exit_properties.sv
`timescale 1ns/1ps
module dsw_exit_checker (
  // Clock and reset
  input wire logic        clock,
  input wire logic        srst,
  // Sleep request and wake inputs
  input wire logic        sleep_request,
  input wire logic        supply_por,
  input wire logic        watchdog_timeout,
  input wire logic        calendar_alarm,
  input wire logic        master_clear_n,
  input wire logic        ext_int_zero,
  input wire logic        brownout,
  // Core and pins
  input wire logic        clear_pending_irq,
  input wire logic        core_reset,
  input wire logic        load_reset_vector,
  input wire logic [15:0] pin_out
);
  default clocking @(posedge clock); endclocking
  default disable iff (srst);
  logic [4:0] por_cnt;
  logic       asleep;
  always_ff @(posedge clock) begin
    if (srst || !core_reset) begin
      por_cnt <= 5'h0;
    end else begin
      por_cnt <= por_cnt + 5'h1;
    end
  end
  // Asleep is only an observer's guess, so it drops as soon as the exit reset shows.
  always_ff @(posedge clock) begin
    if (srst || core_reset) begin
      asleep <= 1'b0;
    end else if (clear_pending_irq) begin
      asleep <= 1'b1;
    end
  end
  property p_lrv_last; load_reset_vector |-> core_reset && por_cnt == 5'h13; endproperty
  a_lrv_last: assert property (p_lrv_last) else $error("reset vector load off the last exit cycle");
  property p_por_end; load_reset_vector |=> !core_reset; endproperty
  a_por_end: assert property (p_por_end) else $error("exit reset outlasts the vector load");
  property p_por_len; core_reset && por_cnt < 5'h13 |=> core_reset; endproperty
  a_por_len: assert property (p_por_len) else $error("exit reset cut short");
  property p_entry; clear_pending_irq |-> sleep_request && !core_reset; endproperty
  a_entry: assert property (p_entry) else $error("pending clear without sleep entry");
  property p_hold; asleep && $past(asleep, 2) |-> $stable(pin_out); endproperty
  a_hold: assert property (p_hold) else $error("pins moved while asleep");
  property p_master_clear_pin; asleep && !core_reset && !master_clear_n |=> core_reset; endproperty
  a_master_clear_pin: assert property (p_master_clear_pin) else $error("master clear did not wake");
  property p_wdt; asleep && !core_reset && watchdog_timeout |=> core_reset; endproperty
  a_wdt: assert property (p_wdt) else $error("watchdog did not wake");
  property p_supply; asleep && !core_reset && supply_por |=> core_reset; endproperty
  a_supply: assert property (p_supply) else $error("supply reset did not wake");
  property p_quiet;
    asleep && !core_reset && master_clear_n && !supply_por && !watchdog_timeout && !calendar_alarm && !brownout
      && $stable(ext_int_zero) |=> !core_reset;
  endproperty
  a_quiet: assert property (p_quiet) else $error("wake without a cause");
  c_sleep: cover property (clear_pending_irq);
  c_master_clear_pin: cover property (asleep && !master_clear_n);
  c_exit: cover property (load_reset_vector);
endmodule

bind dsw_exit dsw_exit_checker u_chk (
  .clock(clock), .srst(srst), .sleep_request(sleep_request), .supply_por(supply_por),
  .watchdog_timeout(watchdog_timeout), .calendar_alarm(calendar_alarm), .master_clear_n(master_clear_n),
  .ext_int_zero(ext_int_zero), .brownout(brownout), .clear_pending_irq(clear_pending_irq),
  .core_reset(core_reset), .load_reset_vector(load_reset_vector), .pin_out(pin_out)
);

// file: test/dsw_wake_pins.sv
`timescale 1ns/1ps
module dsw_wake_pins (
  // Clock
  input  wire logic clock,
  // Wake pins
  output logic      supply_por,
  output logic      watchdog_timeout,
  output logic      calendar_alarm,
  output logic      master_clear_n,
  output logic      ext_int_zero,
  output logic      brownout
);
  initial begin
    supply_por = 1'b0;
    watchdog_timeout = 1'b0;
    calendar_alarm = 1'b0;
    master_clear_n = 1'b1;
    ext_int_zero = 1'b0;
    brownout = 1'b0;
  end
  // The interrupt pin is a level that stays toggled; the others are one-cycle events.
  task automatic strike(input int src);
    @(posedge clock);
    case (src)
      0: supply_por <= 1'b1;
      1: watchdog_timeout <= 1'b1;
      2: calendar_alarm <= 1'b1;
      3: master_clear_n <= 1'b0;
      4: ext_int_zero <= ~ext_int_zero;
      default: brownout <= 1'b1;
    endcase
    @(posedge clock);
    supply_por <= 1'b0;
    watchdog_timeout <= 1'b0;
    calendar_alarm <= 1'b0;
    master_clear_n <= 1'b1;
    brownout <= 1'b0;
  endtask
endmodule

// file: test/tb_deep_sleep_wake_exit.sv
`timescale 1ns/1ps
`include "dsw_defines.svh"
module tb_deep_sleep_wake_exit;
  logic               clock = 1'b0;
  logic               srst = 1'b1;
  logic [3:0]         reg_addr = 4'h0;
  dsw_pkg::dsw_word_t reg_wdata = 16'h0000;
  logic               reg_write = 1'b0;
  logic               reg_read = 1'b0;
  dsw_pkg::dsw_word_t reg_rdata;
  logic               sleep_request = 1'b0;
  logic               supply_por, watchdog_timeout, calendar_alarm, master_clear_n, ext_int_zero, brownout;
  logic               clear_pending_irq, core_reset, load_reset_vector;
  dsw_pkg::dsw_word_t io_direction = 16'h00f0;
  dsw_pkg::dsw_word_t io_latch = 16'h1234;
  dsw_pkg::dsw_word_t pin_out, pin_oe_n;
  int                 miscompares = 0;
  int                 n_compared = 0;
  int                 cycles = 0;

  dsw_exit dut (.clock(clock), .srst(srst), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_write(reg_write),
    .reg_read(reg_read), .reg_rdata(reg_rdata), .sleep_request(sleep_request), .supply_por(supply_por),
    .watchdog_timeout(watchdog_timeout), .calendar_alarm(calendar_alarm), .master_clear_n(master_clear_n),
    .ext_int_zero(ext_int_zero), .brownout(brownout), .clear_pending_irq(clear_pending_irq),
    .core_reset(core_reset), .load_reset_vector(load_reset_vector), .io_direction(io_direction),
    .io_latch(io_latch), .pin_out(pin_out), .pin_oe_n(pin_oe_n));
  dsw_wake_pins pins (.clock(clock), .supply_por(supply_por), .watchdog_timeout(watchdog_timeout),
    .calendar_alarm(calendar_alarm), .master_clear_n(master_clear_n), .ext_int_zero(ext_int_zero),
    .brownout(brownout));

  always #25 clock = ~clock;

  task automatic print_verdict();
    $display("compared %0d, mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) begin
      $display("RESULT: PASS");
    end else begin
      $display("RESULT: FAIL");
    end
    $finish;
  endtask

  always @(posedge clock) begin
    cycles++;
    if (cycles == 20000) begin
      miscompares++;
      print_verdict();
    end
  end

  task automatic check(input string what, input dsw_pkg::dsw_word_t seen, input dsw_pkg::dsw_word_t exp);
    n_compared++;
    if (seen !== exp) begin
      miscompares++;
      $display("unexpected %s: expected %h, seen %h", what, exp, seen);
    end
  endtask
  task automatic wr(input logic [3:0] a, input dsw_pkg::dsw_word_t d);
    @(posedge clock);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clock);
    reg_write <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input dsw_pkg::dsw_word_t exp);
    @(posedge clock);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clock);
    reg_read <= 1'b0;
    #1;
    check($sformatf("register %0h", a), reg_rdata, exp);
  endtask
  task automatic sleep(input dsw_pkg::dsw_word_t ctrl);
    wr(`DSW_ADDR_CTRL, ctrl);
    @(posedge clock);
    sleep_request <= 1'b1;
    #1;
    check("pending clear", {15'h0000, clear_pending_irq}, 16'h0001);
    @(posedge clock);
    sleep_request <= 1'b0;
    rd(`DSW_ADDR_STATUS, 16'h0001);
  endtask
  // A second source fires early in the exit reset; it must leave no trace.
  task automatic wake(input int src, input int late, input dsw_pkg::dsw_word_t bits);
    int n;
    n = 0;
    pins.strike(src);
    #1;
    while (!core_reset && n < 4) begin
      @(posedge clock);
      #1;
      n++;
    end
    pins.strike(late);
    #1;
    n = 2;
    while (core_reset && n < 40) begin
      @(posedge clock);
      #1;
      n++;
    end
    check("exit reset length", 16'(n), 16'(`DSW_POR_CYCLES));
    rd(`DSW_ADDR_WAKESRC, bits);
    rd(`DSW_ADDR_RESETCON, 16'h0400);
    rd(`DSW_ADDR_CTRL, 16'h0000);
    wr(`DSW_ADDR_WAKESRC, 16'h0000);
    wr(`DSW_ADDR_RESETCON, 16'h0000);
    rd(`DSW_ADDR_RESETCON, 16'h0000);
  endtask

  initial begin
    repeat (4) @(posedge clock);
    srst <= 1'b0;
    rd(`DSW_ADDR_CTRL, 16'h0000);
    rd(`DSW_ADDR_SLEEPCON, 16'h0000);
    rd(`DSW_ADDR_WAKESRC, 16'h0000);
    rd(4'hf, 16'h0000);
    wr(`DSW_ADDR_CTXA, 16'h5a5a);
    wr(`DSW_ADDR_CTXB, 16'h3c3c);
    for (int s = 0; s < 5; s++) begin
      io_latch <= 16'h1234;
      io_direction <= 16'h00f0;
      sleep(16'h000f);
      io_latch <= 16'habcd;
      io_direction <= 16'h0f0f;
      wake(s, (s == 1) ? 3 : 1, 16'(1 << s));
      rd(`DSW_ADDR_SLEEPCON, 16'h0001);
      rd(`DSW_ADDR_CTXA, 16'h5a5a);
      rd(`DSW_ADDR_CTXB, 16'h3c3c);
      check("frozen enables", pin_oe_n, 16'h00f0);
      check("frozen levels", pin_out & 16'hff0f, 16'h1204);
      wr(`DSW_ADDR_SLEEPCON, 16'h0000);
      repeat (2) @(posedge clock);
      #1;
      check("released enables", pin_oe_n, 16'h0f0f);
      check("released levels", pin_out & 16'hf0f0, 16'ha0c0);
    end
    pins.strike(4);
    // The second pass enters with the pin already asserted; only a later rise back to it may wake.
    for (int k = 0; k < 2; k++) begin
      sleep(k ? 16'h000d : 16'h0009);
      pins.strike(2);
      pins.strike(4);
      rd(`DSW_ADDR_STATUS, 16'h0001);
      wake(k ? 4 : 3, 1, k ? 16'h0010 : 16'h0008);
      wr(`DSW_ADDR_SLEEPCON, 16'h0000);
    end
    sleep(16'h0011);
    wake(5, 1, 16'h0020);
    rd(`DSW_ADDR_SLEEPCON, 16'h0002);
    rd(`DSW_ADDR_CTXA, 16'h0000);
    check("lossy release", pin_oe_n, io_direction);
    // Low polarity: the pin rests high at entry, so its fall is the wake.
    sleep(16'h0005);
    wake(4, 1, 16'h0010);
    wr(`DSW_ADDR_SLEEPCON, 16'h0000);
    rd(`DSW_ADDR_SLEEPCON, 16'h0000);
    print_verdict();
  end
endmodule
